// [verilog/tm16_map.svh]
`ifndef TM16_MAP_SVH
`define TM16_MAP_SVH

// Bus geometry
`define TM16_ADDR_W 12
`define TM16_NT 7

// Register indices; byte address is four times the index
`define TM16_IDX_T6_CTRL 32'hd4003084
`define TM16_IDX_T6_COUNT 32'hd40030a4
`define TM16_IDX_T6_CMP_A 32'hd40030c4
`define TM16_IDX_T6_CMP_B 32'hd40030d4
`define TM16_IDX_CH_MODE 32'hd40030f0
`define TM16_IDX_RUN_CTRL 32'hd40030f4
`define TM16_IDX_RELOAD4 32'hd4003090
`define TM16_IDX_RELOAD5 32'hd4003092
`define TM16_IDX_RELOAD7 32'hd4003094
`define TM16_IDX_RELOAD8 32'hd4003098
`define TM16_IDX_RELOAD9 32'hd400309a
`define TM16_IDX_RELOAD10 32'hd400309c
`define TM16_IDX_RELOAD11 32'hd400309e
`define TM16_IDX_COUNT4 32'hd40030a0
`define TM16_IDX_COUNT5 32'hd40030a2
`define TM16_IDX_COUNT7 32'hd40030a6
`define TM16_IDX_COUNT8 32'hd40030a8
`define TM16_IDX_COUNT9 32'hd40030aa
`define TM16_IDX_COUNT10 32'h040030ac
`define TM16_IDX_COUNT11 32'h040030ae

// Timer 6 control fields
`define TM16_CNE_BIT 15
`define TM16_LDE_BIT 14
`define TM16_PME_BIT 13
`define TM16_PM_HI 12
`define TM16_PM_LO 11
`define TM16_TGE_BIT 7
`define TM16_ONE_BIT 6
`define TM16_CAE_BIT 4
`define TM16_CK_HI 2
`define TM16_CK_LO 0
`define TM16_CTRL_WMASK 16'hf8d7

// Channel mode fields
`define TM16_MODA_LO 0
`define TM16_MODB_LO 2
`define TM16_EDGA_BIT 4
`define TM16_EDGB_BIT 5

// Down-timer run/load fields
`define TM16_DT_RUN_LO 0
`define TM16_DT_LOAD_LO 8

// Reset values
`define TM16_CTRL_RST 16'h0000
`define TM16_RELOAD_RST 16'h0000
`define TM16_COUNT_RST 16'h0000

// Prescaler taps
`define TM16_DIV8_TAP 3'h7
`define TM16_DIV32_TAP 5'h1f

`endif

// [verilog/tm16_pkg.sv]
package tm16_pkg;
  typedef enum logic [2:0] {
    TM16_SRC_PCLK = 3'h0,
    TM16_SRC_DIV8 = 3'h1,
    TM16_SRC_DIV32 = 3'h2,
    TM16_SRC_NONE = 3'h3,
    TM16_SRC_T0 = 3'h4,
    TM16_SRC_T1 = 3'h5,
    TM16_SRC_T2 = 3'h6,
    TM16_SRC_PIN = 3'h7
  } tm16_src_t;
  typedef enum logic [1:0] {
    TM16_CH_CMP_ONE = 2'h0,
    TM16_CH_CMP_DBL = 2'h1,
    TM16_CH_CAP_ONE = 2'h2,
    TM16_CH_CAP_BOTH = 2'h3
  } tm16_chmode_t;
  typedef logic [6:0] tm16_tmask_t;
endpackage

// [verilog/tm16_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tm16_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Pin levels
  input wire logic [1:0] din,
  output logic [1:0] dout
);
  import tm16_pkg::*;
  logic [1:0] meta_r;

  // Two stages; only the second is read outside
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 2'h0;
      dout <= 2'h0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [verilog/tm16_down_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tm16_map.svh"
module tm16_down_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic load,
  input wire logic tick,
  input wire logic [15:0] reload,
  // Status
  output logic [15:0] count,
  output logic underflow
);
  import tm16_pkg::*;

  // Decrement, reload on zero; period is reload plus one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `TM16_COUNT_RST;
      underflow <= 1'b0;
    end else begin
      underflow <= 1'b0;
      if (load) begin
        count <= reload; // RULE_14
      end else if (run && tick) begin
        if (count == 16'h0000) begin
          count <= reload; // RULE_17
          underflow <= 1'b1; // RULE_16
        end else begin
          count <= count - 16'h0001; // RULE_18
        end
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_UFLOW_RELOAD: assert property ( // RULE_17
    (run && tick && !load && count == 16'h0000)
    |=> (underflow && count == $past(reload)))
    else $error("no reload after underflow");
  AST_UFLOW_AT_ZERO: assert property ( // RULE_16
    underflow |-> $past(count) == 16'h0000)
    else $error("underflow away from zero");
  AST_DECR: assert property ( // RULE_18
    (run && tick && !load && count != 16'h0000)
    |=> count == $past(count) - 16'h0001)
    else $error("counter did not step down");
  AST_LOAD: assert property ( // RULE_14
    load |=> count == $past(reload))
    else $error("load did not copy reload");
endmodule
`default_nettype wire

// [verilog/tm16_timer.sv]
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tm16_map.svh"
// How it works
// (RULE_01) Run bit 15 stops timer 6 at 0 and lets it count at 1.
// (RULE_02) Load bit 14 holds the counter at zero and both outputs low.
// (RULE_03) During load, double-buffered compares copy their buffers.
// (RULE_04) Bit 13 picks normal waveforms or PWM on both pins.
// (RULE_05) Bits 12-11 set PWM resolution 10, 11, 12 or 14 bits.
// (RULE_06) Reserved bits 10-8, 5, 3 read zero; software writes zero.
// (RULE_07) Bit 7 lets a channel B pin edge start counting.
// (RULE_08) Bit 6 one-shot: a compare A match clears the run bit.
// (RULE_09) Bit 4 with compare A: a match clears the counter.
// (RULE_10) Bit 4 with capture A: a capture clears the counter.
// (RULE_11) Bits 2-0 pick the count source; reset value 000.
// (RULE_12) Sources: clock, /8, /32, none, timer 0-2 underflow, pin B.
// (RULE_13) Software never sets run and load together nor switches live.
// (RULE_14) Each 16-bit reload register holds the start value.
// (RULE_15) Counters are readable any time and never writable.
// (RULE_16) Underflow after reload plus one ticks raises an event.
// (RULE_17) On underflow the counter takes the reload value again.
// (RULE_18) Down counters step down per tick, underflowing from zero.
module tm16_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TM16_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Underflow ticks of timers 0 to 2
  input wire logic [2:0] tmr_uflow,
  // Channel A pin
  input wire logic channel_a_pin_in,
  output logic channel_a_pin_out,
  output logic channel_a_pin_oe,
  // Channel B pin
  input wire logic channel_b_pin_in,
  output logic channel_b_pin_out,
  output logic channel_b_pin_oe,
  // Events
  output logic t6_match_a_evt,
  output logic t6_match_b_evt,
  output logic t6_capture_evt,
  output var tm16_pkg::tm16_tmask_t reload_uflow_evt
);
  import tm16_pkg::*;

  logic [15:0] timer6_control_reg;
  logic [5:0] chmode_r;
  logic [15:0] timer6_counter;
  logic [15:0] cmp_a_r;
  logic [15:0] cmp_b_r;
  logic [15:0] buf_a_r;
  logic [15:0] buf_b_r;
  logic [`TM16_NT-1:0] dt_run_r;
  logic [`TM16_NT-1:0] dt_load_r;
  logic [15:0] reload_value_reg [`TM16_NT];
  logic [15:0] down_counter_reg [`TM16_NT];
  logic [4:0] presc_r;
  logic [1:0] pin_s;
  logic a_d_r;
  logic b_d_r;

  // Register address match on the word index
  function automatic logic hit(input logic [`TM16_ADDR_W-1:0] a,
                               input logic [31:0] idx);
    hit = (a[`TM16_ADDR_W-1:2] == idx[`TM16_ADDR_W-3:0]);
  endfunction

  function automatic logic is_cap(input tm16_chmode_t m);
    is_cap = (m == TM16_CH_CAP_ONE) || (m == TM16_CH_CAP_BOTH);
  endfunction

  // Capture edge per mode and edge select
  function automatic logic edge_ok(input tm16_chmode_t m,
                                   input logic fall_sel,
                                   input logic rise,
                                   input logic fall);
    if (m == TM16_CH_CAP_BOTH) begin
      edge_ok = rise | fall;
    end else begin
      edge_ok = fall_sel ? fall : rise;
    end
  endfunction

  // PWM resolution mask: 8 basic plus 2, 3, 4 or 6 bits
  function automatic logic [15:0] pwm_mask(input logic [1:0] pm);
    case (pm)
      2'h0: pwm_mask = 16'h03ff;
      2'h1: pwm_mask = 16'h07ff;
      2'h2: pwm_mask = 16'h0fff;
      default: pwm_mask = 16'h3fff;
    endcase
  endfunction

  function automatic logic [31:0] rl_idx(input int i);
    case (i)
      0: rl_idx = `TM16_IDX_RELOAD4;
      1: rl_idx = `TM16_IDX_RELOAD5;
      2: rl_idx = `TM16_IDX_RELOAD7;
      3: rl_idx = `TM16_IDX_RELOAD8;
      4: rl_idx = `TM16_IDX_RELOAD9;
      5: rl_idx = `TM16_IDX_RELOAD10;
      default: rl_idx = `TM16_IDX_RELOAD11;
    endcase
  endfunction

  function automatic logic [31:0] cnt_idx(input int i);
    case (i)
      0: cnt_idx = `TM16_IDX_COUNT4;
      1: cnt_idx = `TM16_IDX_COUNT5;
      2: cnt_idx = `TM16_IDX_COUNT7;
      3: cnt_idx = `TM16_IDX_COUNT8;
      4: cnt_idx = `TM16_IDX_COUNT9;
      5: cnt_idx = `TM16_IDX_COUNT10;
      default: cnt_idx = `TM16_IDX_COUNT11;
    endcase
  endfunction

  // Control fields
  logic count_run_bit;
  logic init_load_bit;
  logic pwm_select_bit;
  logic pin_trigger_start_bit;
  logic single_shot_bit;
  logic clear_on_channel_a_bit;
  logic [1:0] pwm_resolution_field;
  tm16_src_t count_source_field;
  tm16_chmode_t mode_a;
  tm16_chmode_t mode_b;
  assign count_run_bit = timer6_control_reg[`TM16_CNE_BIT];
  assign init_load_bit = timer6_control_reg[`TM16_LDE_BIT];
  assign pwm_select_bit = timer6_control_reg[`TM16_PME_BIT];
  assign pin_trigger_start_bit = timer6_control_reg[`TM16_TGE_BIT];
  assign single_shot_bit = timer6_control_reg[`TM16_ONE_BIT];
  assign clear_on_channel_a_bit = timer6_control_reg[`TM16_CAE_BIT];
  assign pwm_resolution_field =
    timer6_control_reg[`TM16_PM_HI:`TM16_PM_LO];
  assign count_source_field =
    tm16_src_t'(timer6_control_reg[`TM16_CK_HI:`TM16_CK_LO]);
  assign mode_a = tm16_chmode_t'(chmode_r[`TM16_MODA_LO +: 2]);
  assign mode_b = tm16_chmode_t'(chmode_r[`TM16_MODB_LO +: 2]);

  // Pins cross into mclk through two flops
  tm16_sync sync_u (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({channel_b_pin_in, channel_a_pin_in}),
    .dout(pin_s)
  );

  // Edge memory sits after the synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
    end else begin
      a_d_r <= pin_s[0];
      b_d_r <= pin_s[1];
    end
  end

  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic b_edge;
  assign a_rise = pin_s[0] & ~a_d_r;
  assign a_fall = ~pin_s[0] & a_d_r;
  assign b_rise = pin_s[1] & ~b_d_r;
  assign b_fall = ~pin_s[1] & b_d_r;
  assign b_edge = chmode_r[`TM16_EDGB_BIT] ? b_fall : b_rise;

  // Free-running prescaler for the /8 and /32 sources
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      presc_r <= 5'h00;
    end else begin
      presc_r <= presc_r + 5'h01;
    end
  end

  // Count source selection
  logic tick;
  always_comb begin
    case (count_source_field) // RULE_11
      TM16_SRC_PCLK: tick = 1'b1; // RULE_12
      TM16_SRC_DIV8: tick = (presc_r[2:0] == `TM16_DIV8_TAP);
      TM16_SRC_DIV32: tick = (presc_r == `TM16_DIV32_TAP);
      TM16_SRC_T0: tick = tmr_uflow[0];
      TM16_SRC_T1: tick = tmr_uflow[1];
      TM16_SRC_T2: tick = tmr_uflow[2];
      TM16_SRC_PIN: tick = b_edge;
      default: tick = 1'b0; // Prohibited code never counts
    endcase
  end

  // Timer 6 events
  logic step;
  logic match_a;
  logic match_b;
  logic cap_a;
  logic cap_b;
  logic ovf;
  logic clr_a;
  logic os_clr;
  logic trig;
  logic dbl_xfer;
  assign step = count_run_bit && !init_load_bit && tick; // RULE_01
  assign match_a = step && !is_cap(mode_a) && (timer6_counter == cmp_a_r);
  assign match_b = step && !is_cap(mode_b) && (timer6_counter == cmp_b_r);
  assign cap_a = is_cap(mode_a) &&
    edge_ok(mode_a, chmode_r[`TM16_EDGA_BIT], a_rise, a_fall);
  assign cap_b = is_cap(mode_b) &&
    edge_ok(mode_b, chmode_r[`TM16_EDGB_BIT], b_rise, b_fall);
  assign ovf = step && (timer6_counter == 16'hffff);
  assign clr_a = clear_on_channel_a_bit && (match_a || cap_a); // RULE_09
  assign os_clr = single_shot_bit && match_a; // RULE_08
  assign trig = pin_trigger_start_bit && b_edge; // RULE_07
  // Buffered compares also refresh on a compare A clear, or on overflow when clear is off
  assign dbl_xfer = init_load_bit ||
    (clear_on_channel_a_bit ? match_a : ovf); // RULE_03

  // APB qualifiers: one access cycle, answer prepared at setup
  logic setup;
  logic wr_en;
  logic ctrl_wr;
  logic cmpa_wr;
  logic cmpb_wr;
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pready;
  assign ctrl_wr = wr_en && hit(paddr, `TM16_IDX_T6_CTRL);
  assign cmpa_wr = wr_en && hit(paddr, `TM16_IDX_T6_CMP_A);
  assign cmpb_wr = wr_en && hit(paddr, `TM16_IDX_T6_CMP_B);

  // Control register; pin trigger set wins over any clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer6_control_reg <= `TM16_CTRL_RST; // RULE_11
    end else begin
      if (ctrl_wr) begin
        timer6_control_reg <= pwdata[15:0] & `TM16_CTRL_WMASK; // RULE_06
      end else if (os_clr) begin
        timer6_control_reg[`TM16_CNE_BIT] <= 1'b0; // RULE_08
      end
      if (trig) begin
        timer6_control_reg[`TM16_CNE_BIT] <= 1'b1; // RULE_07
      end
    end
  end

  // Channel modes, down-timer run and load bits
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chmode_r <= 6'h00;
      dt_run_r <= 7'h00;
      dt_load_r <= 7'h00;
    end else begin
      if (wr_en && hit(paddr, `TM16_IDX_CH_MODE)) begin
        chmode_r <= pwdata[5:0];
      end
      if (wr_en && hit(paddr, `TM16_IDX_RUN_CTRL)) begin
        dt_run_r <= pwdata[`TM16_DT_RUN_LO +: `TM16_NT];
        dt_load_r <= pwdata[`TM16_DT_LOAD_LO +: `TM16_NT];
      end
    end
  end

  // Reload registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `TM16_NT; i++) begin
        reload_value_reg[i] <= `TM16_RELOAD_RST;
      end
    end else begin
      for (int i = 0; i < `TM16_NT; i++) begin
        if (wr_en && hit(paddr, rl_idx(i))) begin
          reload_value_reg[i] <= pwdata[15:0]; // RULE_14
        end
      end
    end
  end

  // Down timers run on the peripheral clock
  for (genvar g = 0; g < `TM16_NT; g++) begin : g_dt
    tm16_down_counter dt_u (
      .mclk(mclk),
      .rst_n(rst_n),
      .run(dt_run_r[g]),
      .load(dt_load_r[g]),
      .tick(1'b1),
      .reload(reload_value_reg[g]),
      .count(down_counter_reg[g]),
      .underflow(reload_uflow_evt[g])
    );
  end

  // Timer 6 up counter; software has no write path
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      timer6_counter <= `TM16_COUNT_RST;
    end else if (init_load_bit) begin
      timer6_counter <= 16'h0000; // RULE_02
    end else if (clr_a) begin
      timer6_counter <= 16'h0000; // RULE_10
    end else if (step) begin
      timer6_counter <= timer6_counter + 16'h0001; // RULE_01
    end
  end

  // Compare/capture A and its buffer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a_r <= 16'h0000;
      buf_a_r <= 16'h0000;
    end else begin
      if (cap_a) begin
        cmp_a_r <= timer6_counter;
      end else if (dbl_xfer && mode_a == TM16_CH_CMP_DBL) begin
        cmp_a_r <= buf_a_r; // RULE_03
      end else if (cmpa_wr && mode_a != TM16_CH_CMP_DBL) begin
        cmp_a_r <= pwdata[15:0];
      end
      if (cmpa_wr) begin
        buf_a_r <= pwdata[15:0];
      end
    end
  end

  // Compare/capture B and its buffer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_b_r <= 16'h0000;
      buf_b_r <= 16'h0000;
    end else begin
      if (cap_b) begin
        cmp_b_r <= timer6_counter;
      end else if (dbl_xfer && mode_b == TM16_CH_CMP_DBL) begin
        cmp_b_r <= buf_b_r; // RULE_03
      end else if (cmpb_wr && mode_b != TM16_CH_CMP_DBL) begin
        cmp_b_r <= pwdata[15:0];
      end
      if (cmpb_wr) begin
        buf_b_r <= pwdata[15:0];
      end
    end
  end

  // Waveforms outside PWM: set on own match, reset on the other's
  logic [15:0] pmask;
  assign pmask = pwm_mask(pwm_resolution_field); // RULE_05
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_a_pin_out <= 1'b0;
      channel_b_pin_out <= 1'b0;
    end else if (init_load_bit) begin
      channel_a_pin_out <= 1'b0; // RULE_02
      channel_b_pin_out <= 1'b0;
    end else if (pwm_select_bit) begin
      channel_a_pin_out <=
        (timer6_counter & pmask) < (cmp_a_r & pmask); // RULE_04
      channel_b_pin_out <=
        (timer6_counter & pmask) < (cmp_b_r & pmask); // RULE_04
    end else begin
      if (match_a) begin
        channel_a_pin_out <= 1'b1;
      end else if (match_b) begin
        channel_a_pin_out <= 1'b0;
      end
      if (match_b) begin
        channel_b_pin_out <= 1'b1;
      end else if (match_a) begin
        channel_b_pin_out <= 1'b0;
      end
    end
  end

  // Pin drive and event pulses; B stays input when it feeds the timer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      channel_a_pin_oe <= 1'b0;
      channel_b_pin_oe <= 1'b0;
      t6_match_a_evt <= 1'b0;
      t6_match_b_evt <= 1'b0;
      t6_capture_evt <= 1'b0;
    end else begin
      channel_a_pin_oe <= !is_cap(mode_a);
      channel_b_pin_oe <= !is_cap(mode_b) && !pin_trigger_start_bit &&
        count_source_field != TM16_SRC_PIN;
      t6_match_a_evt <= match_a;
      t6_match_b_evt <= match_b;
      t6_capture_evt <= cap_a || cap_b;
    end
  end

  // Read mux; counters readable, writes to them ignored
  logic [31:0] rdata_nxt;
  logic mapped_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    mapped_nxt = 1'b1;
    if (hit(paddr, `TM16_IDX_T6_CTRL)) begin
      rdata_nxt = {16'h0000, timer6_control_reg}; // RULE_06
    end else if (hit(paddr, `TM16_IDX_T6_COUNT)) begin
      rdata_nxt = {16'h0000, timer6_counter}; // RULE_15
    end else if (hit(paddr, `TM16_IDX_T6_CMP_A)) begin
      rdata_nxt = {16'h0000, cmp_a_r};
    end else if (hit(paddr, `TM16_IDX_T6_CMP_B)) begin
      rdata_nxt = {16'h0000, cmp_b_r};
    end else if (hit(paddr, `TM16_IDX_CH_MODE)) begin
      rdata_nxt = {26'h0000000, chmode_r};
    end else if (hit(paddr, `TM16_IDX_RUN_CTRL)) begin
      rdata_nxt = {17'h00000, dt_load_r, 1'b0, dt_run_r};
    end else begin
      mapped_nxt = 1'b0;
      for (int i = 0; i < `TM16_NT; i++) begin
        if (hit(paddr, rl_idx(i))) begin
          rdata_nxt = {16'h0000, reload_value_reg[i]};
          mapped_nxt = 1'b1;
        end
        if (hit(paddr, cnt_idx(i))) begin
          rdata_nxt = {16'h0000, down_counter_reg[i]}; // RULE_15
          mapped_nxt = 1'b1;
        end
      end
    end
  end

  // Answer registered at setup so outputs come from flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped_nxt;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_nxt;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CNT_HALT: assert property ( // RULE_01
    (!count_run_bit && !init_load_bit && !clr_a)
    |=> $stable(timer6_counter))
    else $error("timer 6 moved while stopped");
  AST_LOAD_CLEAR: assert property ( // RULE_02
    init_load_bit |=> (timer6_counter == 16'h0000 &&
      !channel_a_pin_out && !channel_b_pin_out))
    else $error("load did not clear counter and outputs");
  AST_DBL_XFER: assert property ( // RULE_03
    (init_load_bit && mode_a == TM16_CH_CMP_DBL && !cap_a)
    |=> cmp_a_r == $past(buf_a_r))
    else $error("buffer not copied on load");
  AST_RSVD: assert property ( // RULE_06
    (timer6_control_reg & ~`TM16_CTRL_WMASK) == 16'h0000)
    else $error("reserved control bits set");
  AST_TRIG: assert property ( // RULE_07
    trig |=> count_run_bit)
    else $error("pin trigger did not start timer");
  AST_ONESHOT: assert property ( // RULE_08
    (os_clr && !ctrl_wr && !trig) |=> !count_run_bit)
    else $error("one-shot did not stop timer");
  AST_CLR_MATCH: assert property ( // RULE_09
    (match_a && clear_on_channel_a_bit && !init_load_bit)
    |=> timer6_counter == 16'h0000)
    else $error("match A did not clear counter");
  AST_CLR_CAPT: assert property ( // RULE_10
    (cap_a && clear_on_channel_a_bit)
    |=> (timer6_counter == 16'h0000 &&
      cmp_a_r == $past(timer6_counter)))
    else $error("capture A did not clear counter");
  AST_SRC_NONE: assert property ( // RULE_12
    (count_source_field == TM16_SRC_NONE && !init_load_bit && !clr_a)
    |=> $stable(timer6_counter))
    else $error("prohibited source counted");
  AST_PWM_LOW: assert property ( // RULE_04
    (pwm_select_bit && !init_load_bit && cmp_a_r == 16'h0000)
    |=> !channel_a_pin_out)
    else $error("PWM high with zero duty");
endmodule
`default_nettype wire

// [tb/tm16_pin_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module tm16_pin_partner (
  // Clock
  input wire logic mclk,
  // Design side of both pins
  input wire logic a_out,
  input wire logic a_oe,
  input wire logic b_out,
  input wire logic b_oe,
  // Bench request for one pulse on pin B
  input wire logic fire,
  // Resolved pin levels
  output logic a_in,
  output logic b_in
);
  logic [2:0] left_r = 3'h0;
  // Four clocks high, so the two-flop sync cannot miss the level
  always_ff @(posedge mclk) begin
    if (fire) begin
      left_r <= 3'h4;
    end else if (left_r != 3'h0) begin
      left_r <= left_r - 3'h1;
    end
  end
  // An enabled design driver owns the wire, else the far side drives
  assign a_in = a_oe ? a_out : 1'b0;
  assign b_in = b_oe ? b_out : (left_r != 3'h0);
endmodule
`default_nettype wire

// [tb/test_tm16_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tm16_map.svh"
module test_tm16_timer;
  import tm16_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] tmr_uflow = 3'h0;
  logic fire = 1'b0;
  logic sel_t6 = 1'b0;
  logic pready, pslverr, errv, ev, ma, a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic [31:0] prdata, rdv, hold;
  tm16_tmask_t uf;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] rl [7] = '{`TM16_IDX_RELOAD4, `TM16_IDX_RELOAD5,
    `TM16_IDX_RELOAD7, `TM16_IDX_RELOAD8, `TM16_IDX_RELOAD9,
    `TM16_IDX_RELOAD10, `TM16_IDX_RELOAD11};

  // 20 MHz clock
  always #25 mclk = ~mclk;
  // Event under watch: timer 6 match A or timer 4 underflow
  assign ev = sel_t6 ? ma : uf[0];

  tm16_timer tm16_timer_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .tmr_uflow(tmr_uflow), .channel_a_pin_in(a_in),
    .channel_a_pin_out(a_out), .channel_a_pin_oe(a_oe),
    .channel_b_pin_in(b_in), .channel_b_pin_out(b_out),
    .channel_b_pin_oe(b_oe), .t6_match_a_evt(ma), .t6_match_b_evt(),
    .t6_capture_evt(), .reload_uflow_evt(uf));
  tm16_pin_partner tm16_pin_partner_i (.mclk(mclk), .a_out(a_out),
    .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .fire(fire), .a_in(a_in),
    .b_in(b_in));

  // Verdict; also the exit for any wait that runs out
  task automatic finish_test;
    $display("Compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask
  // One APB transfer, held until pready is seen high
  task automatic xfer(input logic w, input logic [31:0] idx,
      input logic [31:0] wd);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    // Ready is judged at a rising edge; answer taken at that same edge
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      finish_test();
    end
    errv = pslverr;
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rchk(input logic [31:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rdv, exp);
  endtask
  // Clocks up to the next watched event; a missing event fails
  task automatic wev;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (ev !== 1'b1 && n < 300);
    if (n >= 300) begin
      num_errors++;
      finish_test();
    end
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rchk(`TM16_IDX_T6_CTRL, 32'h0);
    rchk(`TM16_IDX_COUNT4, 32'h0);
    wr(`TM16_IDX_T6_COUNT, 32'h1234);
    rchk(`TM16_IDX_T6_COUNT, 32'h0);
    // Ones everywhere but the run bit: reserved bits must drop out
    wr(`TM16_IDX_T6_CTRL, 32'hffff7fff);
    rchk(`TM16_IDX_T6_CTRL, 32'h78d7);
    chk({30'h0, a_out, b_out}, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(`TM16_IDX_T6_CTRL, {19'h0, c[1:0], 8'h0, c[2:0]});
      rchk(`TM16_IDX_T6_CTRL, {19'h0, c[1:0], 8'h0, c[2:0]});
    end
    for (int i = 0; i < 7; i++) begin
      wr(rl[i], {16'h5a5a, 16'h1111 * i[15:0]});
      rchk(rl[i], {16'h0, 16'h1111 * i[15:0]});
    end
    // Unmapped place answers with an error and no data
    xfer(1'b0, 32'h1, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    // Timer 4 period, then a new reload value taken at underflow
    wr(`TM16_IDX_RELOAD4, 32'h5);
    wr(`TM16_IDX_RUN_CTRL, 32'h100);
    wr(`TM16_IDX_RUN_CTRL, 32'h1);
    wev;
    wev;
    chk(n, 32'd6);
    wr(`TM16_IDX_RELOAD4, 32'h2);
    wev;
    wev;
    chk(n, 32'd3);
    wr(`TM16_IDX_RUN_CTRL, 32'h0);
    // Timer 6 interval set by compare A with clear enabled
    sel_t6 = 1'b1;
    wr(`TM16_IDX_T6_CMP_A, 32'h9);
    wr(`TM16_IDX_T6_CTRL, 32'h4000);
    wr(`TM16_IDX_T6_CTRL, 32'h0);
    wr(`TM16_IDX_T6_CTRL, 32'h8010);
    wev;
    wev;
    chk(n, 32'd10);
    wr(`TM16_IDX_T6_CTRL, 32'h0010);
    xfer(1'b0, `TM16_IDX_T6_COUNT, 32'h0);
    hold = rdv;
    repeat (5) @(posedge mclk);
    rchk(`TM16_IDX_T6_COUNT, hold);
    wr(`TM16_IDX_T6_CTRL, 32'h4010);
    rchk(`TM16_IDX_T6_COUNT, 32'h0);
    wr(`TM16_IDX_T6_CTRL, 32'h0050);
    wr(`TM16_IDX_T6_CTRL, 32'h8050);
    wev;
    repeat (2) @(posedge mclk);
    rchk(`TM16_IDX_T6_CTRL, 32'h0050);
    // PWM at 10 bits: high below compare A, high again after the wrap
    wr(`TM16_IDX_T6_CMP_A, 32'h100);
    wr(`TM16_IDX_T6_CTRL, 32'h4000);
    wr(`TM16_IDX_T6_CTRL, 32'ha000);
    repeat (100) @(posedge mclk);
    chk({31'h0, a_out}, 32'h1);
    repeat (300) @(posedge mclk);
    chk({31'h0, a_out}, 32'h0);
    repeat (700) @(posedge mclk);
    chk({31'h0, a_out}, 32'h1);
    // Pin B start, refused and then allowed; B as capture frees the pin
    wr(`TM16_IDX_CH_MODE, 32'h8);
    for (int t = 0; t < 2; t++) begin
      wr(`TM16_IDX_T6_CTRL, 32'h4000);
      wr(`TM16_IDX_T6_CTRL, {24'h0, t[0], 7'h0});
      @(posedge mclk);
      fire <= 1'b1;
      @(posedge mclk);
      fire <= 1'b0;
      repeat (8) @(posedge mclk);
      rchk(`TM16_IDX_T6_CTRL, {16'h0, t[0], 7'h0, t[0], 7'h0});
    end
    finish_test();
  end
endmodule
`default_nettype wire
